// [rcot_top.sv]
// rc oscillator trim, dither, sequence and fail-safe monitor
`timescale 1ns/1ps
`include "rcot_defs.svh"
module rcot_top (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic                        ce,
    input  wire rcot_pkg::rcot_trim_primary_t   trim_reg_primary,
    input  wire rcot_pkg::rcot_trim_secondary_t trim_reg_secondary,
    input  wire rcot_pkg::rcot_ctrl_t        osc_control_reg,
    input  wire rcot_pkg::rcot_src_t         clk_src_select,
    input  wire logic [1:0]                  switch_monitor_select,
    input  wire logic                        pwm_rollover,
    input  wire logic                        primary_clk_tick,
    output logic                             fast_rc_osc_enable,
    output logic                             fast_rc_osc_range_high,
    output logic [`RCOT_TRIM_W-1:0]          fast_rc_osc_trim,
    output logic                             clock_fail_trap,
    output logic                             clock_failed,
    output rcot_pkg::rcot_src_t              sys_clk_source,
    output logic [`RCOT_ROLL_W-1:0]          roll_count
);
    // ******************************************************************
    // rollover counter
    // ******************************************************************
    logic [`RCOT_ROLL_W-1:0] roll_r;
    logic [`RCOT_ROLL_W-1:0] roll_nxt;
    logic                    roll_bit_prev_r;
    logic                    roll_bit_prev_nxt;
    logic                    lfsr_step;

    always_comb begin
        roll_nxt = roll_r;
        if (pwm_rollover) begin
            roll_nxt = roll_r + `RCOT_ROLL_W'(1);
        end
        roll_bit_prev_nxt = roll_r[`RCOT_ROLL_LFSR];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            roll_r          <= '0;
            roll_bit_prev_r <= 1'b0;
        end else if (ce) begin
            roll_r          <= roll_nxt;
            roll_bit_prev_r <= roll_bit_prev_nxt;
        end
    end

    // dither steps on any change of roll bit 3, only while enabled
    assign lfsr_step = (roll_r[`RCOT_ROLL_LFSR] != roll_bit_prev_r)
                       && osc_control_reg.random_dither_enable;

    a_roll_step: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && pwm_rollover) |=> (roll_r == $past(roll_r) + 6'h01))
        else $error("rollover counter did not step");

    a_roll_hold: assert property (@(posedge clk)
        disable iff (!rst_b)
        (!ce || !pwm_rollover) |=> $stable(roll_r))
        else $error("rollover counter moved without a rollover");

    // ******************************************************************
    // dither register
    // ******************************************************************
    logic [`RCOT_LFSR_W-1:0] lfsr_state;

    rcot_lfsr u_lfsr (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .step  (lfsr_step),
        .state (lfsr_state)
    );

    a_lfsr_moves: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && lfsr_step) |=> (lfsr_state != $past(lfsr_state)))
        else $error("dither register did not advance");

    a_lfsr_hold: assert property (@(posedge clk)
        disable iff (!rst_b)
        !(ce && lfsr_step) |=> $stable(lfsr_state))
        else $error("dither register moved without a step");

    a_lfsr_toggle: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && pwm_rollover && roll_r[`RCOT_ROLL_SEL_LO-1:0] == 3'h7)
        |=> (lfsr_step || !osc_control_reg.random_dither_enable))
        else $error("dither step missed on rollover bit change");

    // ******************************************************************
    // trim selection
    // ******************************************************************
    function automatic logic [`RCOT_TRIM_W-1:0] seq_pick(
        input rcot_pkg::rcot_trim_primary_t   p,
        input rcot_pkg::rcot_trim_secondary_t s,
        input logic [2:0]                     sel
    );
        logic [`RCOT_TRIM_W-1:0] v;
        v = p.trim_field;
        unique case (sel)
            3'h0: v = p.trim_field;
            3'h1: v = p.slot1;
            3'h2: v = p.slot2;
            3'h3: v = p.slot3;
            3'h4: v = s.slot4;
            3'h5: v = s.slot5;
            3'h6: v = s.slot6;
            3'h7: v = s.slot7;
        endcase
        return v;
    endfunction : seq_pick

    logic [`RCOT_TRIM_W-1:0] trim_r;
    logic [`RCOT_TRIM_W-1:0] trim_nxt;
    logic [2:0]              seq_sel;

    assign seq_sel = roll_r[`RCOT_ROLL_SEL_HI:`RCOT_ROLL_SEL_LO];

    always_comb begin
        if (osc_control_reg.random_dither_enable) begin
            trim_nxt = lfsr_state[`RCOT_TRIM_W-1:0];
        end else if (osc_control_reg.trim_sequence_enable) begin
            trim_nxt = seq_pick(trim_reg_primary, trim_reg_secondary,
                                seq_sel);
        end else begin
            trim_nxt = trim_reg_primary.trim_field;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            trim_r <= '0;
        end else if (ce) begin
            trim_r <= trim_nxt;
        end
    end

    assign fast_rc_osc_trim = trim_r;

    a_trim_plain: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && !osc_control_reg.random_dither_enable
            && !osc_control_reg.trim_sequence_enable)
        |=> (trim_r == $past(trim_reg_primary.trim_field)))
        else $error("plain trim not applied");

    a_trim_dither: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && osc_control_reg.random_dither_enable)
        |=> (trim_r == $past(lfsr_state[3:0])))
        else $error("dither trim not applied");

    a_trim_seq: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && !osc_control_reg.random_dither_enable
            && osc_control_reg.trim_sequence_enable && seq_sel == 3'h0)
        |=> (trim_r == $past(trim_reg_primary.trim_field)))
        else $error("sequence slot zero wrong");

    a_trim_slot4: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && !osc_control_reg.random_dither_enable
            && osc_control_reg.trim_sequence_enable && seq_sel == 3'h4)
        |=> (trim_r == $past(trim_reg_secondary.slot4)))
        else $error("sequence slot four wrong");

    a_trim_slot7: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && !osc_control_reg.random_dither_enable
            && osc_control_reg.trim_sequence_enable && seq_sel == 3'h7)
        |=> (trim_r == $past(trim_reg_secondary.slot7)))
        else $error("sequence slot seven wrong");

    // ******************************************************************
    // fail-safe clock monitor
    // ******************************************************************
    rcot_pkg::rcot_mon_state_t mon_r;
    rcot_pkg::rcot_mon_state_t mon_nxt;
    logic [`RCOT_CNT_W-1:0]    idle_cnt_r;
    logic [`RCOT_CNT_W-1:0]    idle_cnt_nxt;
    logic                      tick_s1_r;
    logic                      tick_s2_r;
    logic                      tick_s3_r;
    logic                      trap_r;
    logic                      trap_nxt;
    logic                      mon_en;

    // monitor off only for the disabling select code
    assign mon_en = (switch_monitor_select != `RCOT_MON_OFF);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
            tick_s3_r <= 1'b0;
        end else if (ce) begin
            tick_s1_r <= primary_clk_tick;
            tick_s2_r <= tick_s1_r;
            tick_s3_r <= tick_s2_r;
        end
    end

    always_comb begin
        mon_nxt      = mon_r;
        idle_cnt_nxt = idle_cnt_r;
        trap_nxt     = 1'b0;
        unique case (mon_r)
            rcot_pkg::RCOT_MON_IDLE: begin
                idle_cnt_nxt = '0;
                if (mon_en && clk_src_select != rcot_pkg::RCOT_SRC_FAST_RC) begin
                    mon_nxt = rcot_pkg::RCOT_MON_WATCH;
                end
            end
            rcot_pkg::RCOT_MON_WATCH: begin
                if (!mon_en || clk_src_select == rcot_pkg::RCOT_SRC_FAST_RC) begin
                    mon_nxt = rcot_pkg::RCOT_MON_IDLE;
                end else if (tick_s2_r != tick_s3_r) begin
                    idle_cnt_nxt = '0;
                end else if (idle_cnt_r == `RCOT_FAIL_LIMIT) begin
                    mon_nxt  = rcot_pkg::RCOT_MON_FAILED;
                    trap_nxt = 1'b1;
                end else begin
                    idle_cnt_nxt = idle_cnt_r + `RCOT_CNT_W'(1);
                end
            end
            rcot_pkg::RCOT_MON_FAILED: begin
                // held until reset
                mon_nxt = rcot_pkg::RCOT_MON_FAILED;
            end
            default: mon_nxt = rcot_pkg::RCOT_MON_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mon_r      <= rcot_pkg::RCOT_MON_IDLE;
            idle_cnt_r <= '0;
            trap_r     <= 1'b0;
        end else if (ce) begin
            mon_r      <= mon_nxt;
            idle_cnt_r <= idle_cnt_nxt;
            trap_r     <= trap_nxt;
        end
    end

    assign clock_fail_trap = trap_r;
    assign clock_failed    = (mon_r == rcot_pkg::RCOT_MON_FAILED);

    a_trap_switch: assert property (@(posedge clk)
        disable iff (!rst_b)
        clock_fail_trap |-> (clock_failed
            && sys_clk_source == rcot_pkg::RCOT_SRC_FAST_RC))
        else $error("trap without switch to rc");

    a_mon_gate: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && !mon_en && mon_r != rcot_pkg::RCOT_MON_FAILED)
        |=> !clock_fail_trap)
        else $error("trap with monitor disabled");

    a_fail_latch: assert property (@(posedge clk)
        disable iff (!rst_b)
        clock_failed |=> clock_failed)
        else $error("failure state lost before reset");

    a_trap_pulse: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && clock_fail_trap) |=> !clock_fail_trap)
        else $error("trap longer than one cycle");

    a_mon_off: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ce && !mon_en) |=> (mon_r != rcot_pkg::RCOT_MON_WATCH))
        else $error("monitor watching while disabled");

    // ******************************************************************
    // power, range and source
    // ******************************************************************
    logic range_r;
    logic range_nxt;

    assign range_nxt = osc_control_reg.range_high;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            range_r <= 1'b0;
        end else if (ce) begin
            range_r <= range_nxt;
        end
    end

    assign fast_rc_osc_range_high = range_r;
    assign sys_clk_source = clock_failed ? rcot_pkg::RCOT_SRC_FAST_RC
                                         : clk_src_select;
    assign fast_rc_osc_enable =
        (clk_src_select != rcot_pkg::RCOT_SRC_EXT_CLOCK
         && clk_src_select != rcot_pkg::RCOT_SRC_HS_CRYSTAL)
        || clock_failed;
    assign roll_count = roll_r;

    a_osc_power: assert property (@(posedge clk)
        disable iff (!rst_b)
        clock_failed |-> fast_rc_osc_enable)
        else $error("rc oscillator off after failure");

    a_osc_select: assert property (@(posedge clk)
        disable iff (!rst_b)
        (clk_src_select == rcot_pkg::RCOT_SRC_FAST_RC)
        |-> fast_rc_osc_enable)
        else $error("rc oscillator off while selected");

    a_range_copy: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce |=> (fast_rc_osc_range_high == $past(osc_control_reg.range_high)))
        else $error("range select not applied");
endmodule : rcot_top

// [rcot_defs.svh]
// constants for the rc oscillator trim control block
`ifndef RCOT_DEFS_SVH
`define RCOT_DEFS_SVH
`define RCOT_TRIM_W      4
`define RCOT_LFSR_W      15
`define RCOT_LFSR_SEED   15'h0001
`define RCOT_LFSR_TAP_A  14
`define RCOT_LFSR_TAP_B  13
`define RCOT_ROLL_W      6
`define RCOT_ROLL_SEL_HI 5
`define RCOT_ROLL_SEL_LO 3
`define RCOT_ROLL_LFSR   3
`define RCOT_SLOTS       8
`define RCOT_FAIL_LIMIT  8'h40
`define RCOT_CNT_W       8
`define RCOT_MON_OFF     2'h3
`endif

// [rcot_pkg.sv]
// types for the rc oscillator trim control block
package rcot_pkg;
    typedef enum logic [1:0] {
        RCOT_SRC_FAST_RC,
        RCOT_SRC_EXT_CLOCK,
        RCOT_SRC_HS_CRYSTAL,
        RCOT_SRC_OTHER
    } rcot_src_t;

    typedef struct packed {
        logic [3:0] trim_field;
        logic [3:0] slot1;
        logic [3:0] slot2;
        logic [3:0] slot3;
    } rcot_trim_primary_t;

    typedef struct packed {
        logic [3:0] slot4;
        logic [3:0] slot5;
        logic [3:0] slot6;
        logic [3:0] slot7;
    } rcot_trim_secondary_t;

    typedef struct packed {
        logic trim_sequence_enable;
        logic random_dither_enable;
        logic range_high;
    } rcot_ctrl_t;

    typedef enum logic [1:0] {
        RCOT_MON_IDLE,
        RCOT_MON_WATCH,
        RCOT_MON_FAILED
    } rcot_mon_state_t;
endpackage : rcot_pkg

// [rcot_lfsr.sv]
// pseudo-random dither shift register
`timescale 1ns/1ps
`include "rcot_defs.svh"
module rcot_lfsr (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     ce,
    input  wire logic                     step,
    output logic [`RCOT_LFSR_W-1:0]       state
);
    logic [`RCOT_LFSR_W-1:0] state_r;
    logic [`RCOT_LFSR_W-1:0] state_nxt;

    // x^15 + x^14 + 1, maximal length
    always_comb begin
        state_nxt = state_r;
        if (step) begin
            state_nxt = {state_r[`RCOT_LFSR_W-2:0],
                         state_r[`RCOT_LFSR_TAP_A] ^
                         state_r[`RCOT_LFSR_TAP_B]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= `RCOT_LFSR_SEED;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign state = state_r;

    a_lfsr_nonzero: assert property (@(posedge clk)
        disable iff (!rst_b)
        state_r != '0) else $error("lfsr locked at zero");
endmodule : rcot_lfsr

// [rcot_pwm_model.sv]
// pwm time base and primary oscillator model
`timescale 1ns/1ps
module rcot_pwm_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [1:0] gap,
    input  wire logic       tick_run,
    output logic            pwm_rollover,
    output logic            primary_clk_tick
);
    logic [1:0] cnt_r = 2'h0;
    logic [2:0] div_r = 3'h0;
    initial pwm_rollover = 1'b0;
    initial primary_clk_tick = 1'b0;
    // one pulse per period of gap+1 cycles
    always @(negedge clk) begin
        pwm_rollover <= go && cnt_r == gap;
        cnt_r <= (!go || cnt_r == gap) ? 2'h0 : cnt_r + 2'h1;
        div_r <= div_r + 3'h1;
        if (tick_run && div_r == 3'h0) begin
            primary_clk_tick <= !primary_clk_tick;
        end
    end
endmodule : rcot_pwm_model

// [rcot_top_bench.sv]
// self-checking bench for the rc oscillator trim block
`timescale 1ns/1ps
`include "rcot_defs.svh"
module rcot_top_bench;
    logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, tick_run = 1'b1, ce = 1'b1;
    logic [1:0] gap = 2'h0, mon_sel = 2'h0;
    rcot_pkg::rcot_trim_primary_t   prim = 16'h0000;
    rcot_pkg::rcot_trim_secondary_t sec = 16'h0000;
    rcot_pkg::rcot_ctrl_t           ctrl = 3'h0;
    rcot_pkg::rcot_src_t            src = rcot_pkg::RCOT_SRC_FAST_RC;
    logic pwm_rollover, primary_clk_tick, rc_en, rc_hi, trap, failed;
    logic [3:0] trim;
    rcot_pkg::rcot_src_t sys_src;
    logic [5:0] roll, exp_roll;
    logic [14:0] exp_lfsr;
    logic b3_r;
    int failures = 0, checked = 0, trap_cnt, n, seed;

    always #12.5 clk = ~clk;

    rcot_pwm_model pm (.clk(clk), .go(go), .gap(gap), .tick_run(tick_run),
        .pwm_rollover(pwm_rollover), .primary_clk_tick(primary_clk_tick));

    rcot_top dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .trim_reg_primary(prim), .trim_reg_secondary(sec),
        .osc_control_reg(ctrl), .clk_src_select(src),
        .switch_monitor_select(mon_sel), .pwm_rollover(pwm_rollover),
        .primary_clk_tick(primary_clk_tick), .fast_rc_osc_enable(rc_en),
        .fast_rc_osc_range_high(rc_hi), .fast_rc_osc_trim(trim),
        .clock_fail_trap(trap), .clock_failed(failed),
        .sys_clk_source(sys_src), .roll_count(roll));

    function automatic logic [14:0] lfsr_next(logic [14:0] s);
        return {s[13:0], s[14] ^ s[13]};
    endfunction : lfsr_next

    function automatic logic [3:0] exp_trim();
        logic [31:0] all;
        all = {prim, sec};
        if (ctrl.random_dither_enable) return exp_lfsr[3:0];
        if (ctrl.trim_sequence_enable) return all[31-4*exp_roll[5:3] -: 4];
        return prim.trim_field;
    endfunction : exp_trim

    // reference rollover count and dither register
    always @(posedge clk) begin
        if (!rst_b) begin
            exp_roll <= 6'h00;
            exp_lfsr <= `RCOT_LFSR_SEED;
            b3_r <= 1'b0;
            trap_cnt <= 0;
        end else if (ce) begin
            if (pwm_rollover) exp_roll <= exp_roll + 6'h01;
            b3_r <= exp_roll[3];
            if (ctrl.random_dither_enable && b3_r != exp_roll[3]) begin
                exp_lfsr <= lfsr_next(exp_lfsr);
            end
            if (trap) trap_cnt <= trap_cnt + 1;
        end
    end

    task check(logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task test_done;
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task settle(int k);
        repeat (k) @(negedge clk);
    endtask : settle

    task run_pulses(int k);
        go <= 1'b1;
        gap <= 2'($urandom);
        // clock enable drops at random, freezing the block
        repeat (k) begin
            ce <= ($urandom % 4) != 0;
            @(negedge clk);
        end
        go <= 1'b0;
        ce <= 1'b1;
        settle(8);
        check(16'(roll), 16'(exp_roll));
        check(16'(trim), 16'(exp_trim()));
    endtask : run_pulses

    initial begin
        #(25 * 60000);
        failures++;
        test_done;
    end

    // ***********************
    // main sequence
    // ***********************
    initial begin
        seed = $urandom(32'hcfc5);
        settle(16);
        rst_b <= 1'b1;
        settle(2);
        check(16'({trim, rc_hi, trap, failed, roll}), 16'h0);
        for (int i = 0; i < 4; i++) begin
            src <= rcot_pkg::rcot_src_t'(i);
            settle(2);
            check(16'(rc_en), 16'(i != 1 && i != 2));
            check(16'(sys_src), 16'(i));
        end
        src <= rcot_pkg::RCOT_SRC_FAST_RC;
        for (int i = 0; i < 10; i++) begin
            prim <= 16'($urandom);
            sec <= 16'($urandom);
            ctrl <= {2'b00, 1'($urandom)};
            settle(3);
            check(16'(rc_hi), 16'(ctrl.range_high));
            check(16'(trim), 16'(prim.trim_field));
        end
        ctrl <= 3'b100;
        for (int i = 0; i < 24; i++) begin
            run_pulses($urandom % 40 + 1);
        end
        for (int i = 0; i < 20; i++) begin
            ctrl <= {1'($urandom), 1'b1, 1'b0};
            run_pulses($urandom % 60 + 1);
        end
        ctrl <= 3'b100;
        run_pulses(30);
        src <= rcot_pkg::RCOT_SRC_HS_CRYSTAL;
        mon_sel <= `RCOT_MON_OFF;
        tick_run <= 1'b0;
        settle(150);
        check(16'({trap_cnt[3:0], failed}), 16'h0);
        mon_sel <= 2'h0;
        n = 0;
        while (trap_cnt == 0 && n < 200) begin
            settle(1);
            n++;
        end
        // one edge to watch, limit plus one idle edges, one to count
        check(16'(n), 16'(`RCOT_FAIL_LIMIT + 3));
        settle(1);
        check(16'({failed, rc_en}), 16'h3);
        check(16'(sys_src), 16'(rcot_pkg::RCOT_SRC_FAST_RC));
        rst_b <= 1'b0;
        tick_run <= 1'b1;
        src <= rcot_pkg::RCOT_SRC_EXT_CLOCK;
        settle(16);
        rst_b <= 1'b1;
        settle(3);
        check(16'({failed, rc_en}), 16'h0);
        tick_run <= 1'b0;
        n = 0;
        while (trap_cnt == 0 && n < 200) begin
            settle(1);
            n++;
        end
        check(16'(n >= 56 && n <= 80), 16'h1);
        settle(20);
        tick_run <= 1'b1;
        settle(20);
        check(16'({trap_cnt[3:0], failed}), 16'h3);
        test_done;
    end
endmodule : rcot_top_bench
